/* File: verilog/rxqfd_defines.svh */
`ifndef RXQFD_DEFINES_SVH
`define RXQFD_DEFINES_SVH

// descriptor layout inside a frame's memory area
`define RXQFD_STATUS_OFS     12'h000
`define RXQFD_COUNT_OFS      12'h002
`define RXQFD_DATA_OFS       12'h004
`define RXQFD_DATA_MAX       11'd1916
`define RXQFD_MEM_BYTES      4096

// status word fields
`define RXQFD_ST_VALID       15
`define RXQFD_ST_PORT_HI     9
`define RXQFD_ST_PORT_LO     8
`define RXQFD_ST_BCAST       7
`define RXQFD_ST_MCAST       6
`define RXQFD_ST_UCAST       5
`define RXQFD_ST_TYPE        3
`define RXQFD_ST_LONG        2
`define RXQFD_ST_RUNT        1
`define RXQFD_ST_CRC         0
`define RXQFD_PORT1          2'h1
`define RXQFD_PORT2          2'h2
`define RXQFD_CNT_W          11

// frame limits
`define RXQFD_TYPE_LIMIT     16'h05dc
`define RXQFD_LEN_LIMIT      11'd1518
`define RXQFD_MIN_FRAME      11'd64
`define RXQFD_FCS_BYTES      11'd4
`define RXQFD_DA_LAST        11'd5
`define RXQFD_TYPE_HI_IDX    11'd12
`define RXQFD_TYPE_LO_IDX    11'd13

// register map (byte addresses)
`define RXQFD_REG_CTRL       13'h0000
`define RXQFD_REG_STAT       13'h0004
`define RXQFD_REG_ISR        13'h0008
`define RXQFD_REG_IMR        13'h000c
`define RXQFD_MEM_SEL_BIT    12

// control bits
`define RXQFD_CTRL_PASS_BAD  0
`define RXQFD_CTRL_CRC_STRIP 1
`define RXQFD_CTRL_RELEASE   2

// interrupt bits
`define RXQFD_INT_W          3
`define RXQFD_INT_READY      0
`define RXQFD_INT_DISCARD    1
`define RXQFD_INT_OVERRUN    2

`endif

/* File: verilog/rxqfd_pkg.sv */
package rxqfd_pkg;

    // byte stream from the mac/phy side
    typedef struct packed {
        logic       valid;
        logic       sop;
        logic       eop;
        logic [7:0] data;
        logic       port2;
        logic       collision;
        logic       crc_err;
    } rxqfd_mac_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [12:0] addr;
    } rxqfd_aphase_t;

    typedef enum logic [2:0] {
        RXQFD_IDLE,
        RXQFD_RECV,
        RXQFD_DESC,
        RXQFD_HOLD,
        RXQFD_DROP
    } rxqfd_state_t;

endpackage

/* File: verilog/rxqfd_frame_descriptor.sv */
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "rxqfd_defines.svh"

module rxqfd_frame_descriptor #(
    parameter int MEM_BYTES = `RXQFD_MEM_BYTES
) (
    // clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 sys_rst_i,
    // mac/phy receive stream
    input  wire rxqfd_pkg::rxqfd_mac_t mac_i,
    // ahb-lite slave
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic      [31:0]          hrdata_o,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    // interrupt
    output logic                      irq_o
);

    localparam int WORDS = MEM_BYTES / 4;
    localparam int AW    = $clog2(WORDS);

    // rx packet memory, word 0 is kept in desc_r instead
    logic [31:0] mem [WORDS];

    rxqfd_pkg::rxqfd_state_t state_r, state_nxt;
    logic [10:0] idx_r,   idx_nxt;
    logic        bcast_r, bcast_nxt;
    logic        mcast_r, mcast_nxt;
    logic [7:0]  type_hi_r, type_hi_nxt;
    logic        ftype_r, ftype_nxt;
    logic        port2_r, port2_nxt;
    logic        coll_r,  coll_nxt;
    logic [31:0] desc_r,  desc_nxt;

    logic        pass_bad_r,  pass_bad_nxt;
    logic        crc_strip_r, crc_strip_nxt;
    logic [`RXQFD_INT_W-1:0] isr_r, isr_nxt;
    logic [`RXQFD_INT_W-1:0] imr_r, imr_nxt;
    logic [`RXQFD_INT_W-1:0] ev_set;

    rxqfd_pkg::rxqfd_aphase_t ap_r, ap_nxt;
    logic        rd_wait_r, rd_wait_nxt;
    logic [31:0] hrdata_r,  hrdata_nxt;

    logic        wr_ctrl, wr_isr, wr_imr, release_req;
    logic        byte_we;
    logic [11:0] byte_addr;
    logic [15:0] status_w;
    logic [10:0] total;
    logic [10:0] wr_idx;
    logic        bad, too_long, runt;

    function automatic logic [11:0] data_addr(input logic [10:0] i);
        data_addr = 12'(i) + `RXQFD_DATA_OFS;
    endfunction

    function automatic logic reg_hit(input logic [12:0] a,
                                     input logic [12:0] ofs);
        reg_hit = (a[`RXQFD_MEM_SEL_BIT] == 1'b0) && (a[11:2] == ofs[11:2]);
    endfunction

    // --- ahb-lite slave ---
    always_comb begin
        ap_nxt       = ap_r;
        ap_nxt.valid = 1'b0;
        if (hsel_i && htrans_i[1] && hready_i) begin
            ap_nxt.valid = 1'b1;
            ap_nxt.write = hwrite_i;
            ap_nxt.addr  = haddr_i[12:0];
        end
        rd_wait_nxt = ap_r.valid && !ap_r.write;
        hrdata_nxt  = hrdata_r;
        // load in the wait cycle so data stand in the second cycle
        if (rd_wait_nxt && !rd_wait_r) begin
            hrdata_nxt = 32'h0000_0000;
            if (ap_r.addr[`RXQFD_MEM_SEL_BIT]) begin
                // word 0 mirrors the live descriptor
                if (ap_r.addr[11:2] == 10'h000) begin
                    hrdata_nxt = desc_r;
                end else begin
                    hrdata_nxt = mem[ap_r.addr[AW+1:2]];
                end
            end else if (reg_hit(ap_r.addr, `RXQFD_REG_CTRL)) begin
                hrdata_nxt[`RXQFD_CTRL_PASS_BAD]  = pass_bad_r;
                hrdata_nxt[`RXQFD_CTRL_CRC_STRIP] = crc_strip_r;
            end else if (reg_hit(ap_r.addr, `RXQFD_REG_STAT)) begin
                hrdata_nxt[0] = (state_r == rxqfd_pkg::RXQFD_HOLD);
                hrdata_nxt[1] = (state_r == rxqfd_pkg::RXQFD_RECV);
            end else if (reg_hit(ap_r.addr, `RXQFD_REG_ISR)) begin
                hrdata_nxt[`RXQFD_INT_W-1:0] = isr_r;
            end else if (reg_hit(ap_r.addr, `RXQFD_REG_IMR)) begin
                hrdata_nxt[`RXQFD_INT_W-1:0] = imr_r;
            end
        end
    end

    // reads take one wait state so data leave a flip-flop
    assign hreadyout_o = !(ap_r.valid && !ap_r.write && !rd_wait_r)
                         || rd_wait_r;
    assign hrdata_o    = hrdata_r;
    assign hresp_o     = 1'b0;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ap_r      <= '0;
            rd_wait_r <= 1'b0;
            hrdata_r  <= 32'h0000_0000;
        end else begin
            ap_r      <= (rd_wait_nxt && !rd_wait_r) ? ap_r : ap_nxt;
            rd_wait_r <= rd_wait_nxt && !rd_wait_r;
            hrdata_r  <= hrdata_nxt;
        end
    end

    // --- control and interrupt registers ---
    assign wr_ctrl = ap_r.valid && ap_r.write
                     && reg_hit(ap_r.addr, `RXQFD_REG_CTRL);
    assign wr_isr  = ap_r.valid && ap_r.write
                     && reg_hit(ap_r.addr, `RXQFD_REG_ISR);
    assign wr_imr  = ap_r.valid && ap_r.write
                     && reg_hit(ap_r.addr, `RXQFD_REG_IMR);
    assign release_req = wr_ctrl && hwdata_i[`RXQFD_CTRL_RELEASE];

    always_comb begin
        pass_bad_nxt  = pass_bad_r;
        crc_strip_nxt = crc_strip_r;
        imr_nxt       = imr_r;
        if (wr_ctrl) begin
            pass_bad_nxt  = hwdata_i[`RXQFD_CTRL_PASS_BAD];
            crc_strip_nxt = hwdata_i[`RXQFD_CTRL_CRC_STRIP];
        end
        if (wr_imr) begin
            imr_nxt = hwdata_i[`RXQFD_INT_W-1:0];
        end
        // set beats a write-one clear in the same cycle
        isr_nxt = isr_r;
        if (wr_isr) begin
            isr_nxt = isr_r & ~hwdata_i[`RXQFD_INT_W-1:0];
        end
        isr_nxt = isr_nxt | ev_set;
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pass_bad_r  <= 1'b0;
            crc_strip_r <= 1'b0;
            isr_r       <= '0;
            imr_r       <= '0;
        end else begin
            pass_bad_r  <= pass_bad_nxt;
            crc_strip_r <= crc_strip_nxt;
            isr_r       <= isr_nxt;
            imr_r       <= imr_nxt;
        end
    end

    assign irq_o = |(isr_r & imr_r);

    // --- frame formatter ---
    assign total    = idx_r;
    assign too_long = total > `RXQFD_LEN_LIMIT;
    assign runt     = coll_r || (total < `RXQFD_MIN_FRAME);
    assign bad      = too_long || runt || desc_r[`RXQFD_ST_CRC];

    always_comb begin
        status_w = 16'h0000;
        status_w[`RXQFD_ST_VALID] = 1'b1;
        status_w[`RXQFD_ST_PORT_HI:`RXQFD_ST_PORT_LO] =
            port2_r ? `RXQFD_PORT2 : `RXQFD_PORT1;
        status_w[`RXQFD_ST_BCAST] = bcast_r;
        status_w[`RXQFD_ST_MCAST] = mcast_r;
        status_w[`RXQFD_ST_UCAST] = !mcast_r;
        status_w[`RXQFD_ST_TYPE]  = ftype_r && !runt;
        status_w[`RXQFD_ST_LONG]  = too_long;
        status_w[`RXQFD_ST_RUNT]  = runt;
        status_w[`RXQFD_ST_CRC]   = desc_r[`RXQFD_ST_CRC];
    end

    // idx_r still holds the last frame's count while idle
    assign wr_idx    = (state_r == rxqfd_pkg::RXQFD_IDLE) ? 11'd0 : idx_r;
    assign byte_addr = data_addr(wr_idx);
    // bytes past the data area are counted, not stored
    assign byte_we = mac_i.valid && (wr_idx < `RXQFD_DATA_MAX)
                     && ((state_r == rxqfd_pkg::RXQFD_RECV)
                     || ((state_r == rxqfd_pkg::RXQFD_IDLE) && mac_i.sop));

    always_comb begin
        state_nxt   = state_r;
        idx_nxt     = idx_r;
        bcast_nxt   = bcast_r;
        mcast_nxt   = mcast_r;
        type_hi_nxt = type_hi_r;
        ftype_nxt   = ftype_r;
        port2_nxt   = port2_r;
        coll_nxt    = coll_r;
        desc_nxt    = desc_r;
        ev_set      = '0;
        case (state_r)
            rxqfd_pkg::RXQFD_IDLE: begin
                if (mac_i.valid && mac_i.sop) begin
                    state_nxt = mac_i.eop ? rxqfd_pkg::RXQFD_DESC
                                          : rxqfd_pkg::RXQFD_RECV;
                    idx_nxt   = 11'd1;
                    bcast_nxt = (mac_i.data == 8'hff);
                    mcast_nxt = mac_i.data[0];
                    ftype_nxt = 1'b0;
                    port2_nxt = mac_i.port2;
                    coll_nxt  = mac_i.collision;
                    desc_nxt  = 32'h0000_0000;
                    desc_nxt[`RXQFD_ST_CRC] = mac_i.eop && mac_i.crc_err;
                end
            end
            rxqfd_pkg::RXQFD_RECV: begin
                if (mac_i.valid) begin
                    if (idx_r != {`RXQFD_CNT_W{1'b1}}) begin
                        idx_nxt = idx_r + 11'd1;
                    end
                    if (idx_r <= `RXQFD_DA_LAST) begin
                        bcast_nxt = bcast_r && (mac_i.data == 8'hff);
                    end
                    if (idx_r == `RXQFD_TYPE_HI_IDX) begin
                        type_hi_nxt = mac_i.data;
                    end
                    if (idx_r == `RXQFD_TYPE_LO_IDX) begin
                        ftype_nxt = {type_hi_r, mac_i.data}
                                    > `RXQFD_TYPE_LIMIT;
                    end
                    coll_nxt = coll_r || mac_i.collision;
                    if (mac_i.eop) begin
                        desc_nxt[`RXQFD_ST_CRC] = mac_i.crc_err;
                        state_nxt = rxqfd_pkg::RXQFD_DESC;
                    end
                end
            end
            rxqfd_pkg::RXQFD_DESC: begin
                if (bad && !pass_bad_r) begin
                    state_nxt = rxqfd_pkg::RXQFD_IDLE;
                    ev_set[`RXQFD_INT_DISCARD] = 1'b1;
                end else begin
                    // descriptor and valid bit appear together
                    desc_nxt[15:0]  = status_w;
                    desc_nxt[31:16] = 16'h0000;
                    desc_nxt[16 +: `RXQFD_CNT_W] =
                        (crc_strip_r && total >= `RXQFD_FCS_BYTES)
                        ? total - `RXQFD_FCS_BYTES : total;
                    state_nxt = rxqfd_pkg::RXQFD_HOLD;
                    ev_set[`RXQFD_INT_READY] = 1'b1;
                end
            end
            rxqfd_pkg::RXQFD_HOLD: begin
                // one frame at a time, so status cannot drift
                if (mac_i.valid && mac_i.sop) begin
                    ev_set[`RXQFD_INT_OVERRUN] = 1'b1;
                    if (!mac_i.eop) begin
                        state_nxt = rxqfd_pkg::RXQFD_DROP;
                    end
                end
                if (release_req) begin
                    desc_nxt = 32'h0000_0000;
                    if (state_nxt == rxqfd_pkg::RXQFD_HOLD) begin
                        state_nxt = rxqfd_pkg::RXQFD_IDLE;
                    end
                end
            end
            rxqfd_pkg::RXQFD_DROP: begin
                if (release_req) begin
                    desc_nxt = 32'h0000_0000;
                end
                if (mac_i.valid && mac_i.eop) begin
                    state_nxt = (desc_nxt[`RXQFD_ST_VALID])
                                ? rxqfd_pkg::RXQFD_HOLD
                                : rxqfd_pkg::RXQFD_IDLE;
                end
            end
            default: begin
                state_nxt = rxqfd_pkg::RXQFD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r   <= rxqfd_pkg::RXQFD_IDLE;
            idx_r     <= 11'd0;
            bcast_r   <= 1'b0;
            mcast_r   <= 1'b0;
            type_hi_r <= 8'h00;
            ftype_r   <= 1'b0;
            port2_r   <= 1'b0;
            coll_r    <= 1'b0;
            desc_r    <= 32'h0000_0000;
        end else begin
            state_r   <= state_nxt;
            idx_r     <= idx_nxt;
            bcast_r   <= bcast_nxt;
            mcast_r   <= mcast_nxt;
            type_hi_r <= type_hi_nxt;
            ftype_r   <= ftype_nxt;
            port2_r   <= port2_nxt;
            coll_r    <= coll_nxt;
            desc_r    <= desc_nxt;
        end
    end

    // fcs bytes land in memory; with crc_strip_r set they sit past the reported count
    always_ff @(posedge core_clk_i) begin
        if (byte_we) begin
            mem[byte_addr[AW+1:2]][byte_addr[1:0]*8 +: 8] <= mac_i.data;
        end
    end

endmodule

/* File: verification/rxqfd_properties.sv */
`timescale 1ns/1ps
module rxqfd_chk (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // ahb-lite
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_o,
    input  wire logic        hreadyout_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic take;
    logic dd;
    logic rd_r;
    logic rd_nxt;
    logic dsc_r;
    logic dsc_nxt;
    assign take = hsel_i & htrans_i[1] & hready_i;
    // dd marks the edge that returns the descriptor word
    assign dd = dsc_r & hreadyout_o;

    always_comb begin
        rd_nxt = rd_r;
        dsc_nxt = dsc_r;
        if (hreadyout_o) begin
            rd_nxt = take & ~hwrite_i;
            dsc_nxt = rd_nxt && haddr_i[12:0] == 13'h1000;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_r <= 1'b0;
            dsc_r <= 1'b0;
        end else begin
            rd_r <= rd_nxt;
            dsc_r <= dsc_nxt;
        end
    end

    sequence s_rd;
        take && !hwrite_i;
    endsequence
    sequence s_wait1;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    a_read_wait: assert property (s_rd |=> s_wait1)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    a_rsvd_zero: assert property (dd |-> hrdata_o[14:10] == 5'h00
        && !hrdata_o[4] && hrdata_o[31:27] == 5'h00)
        else $error("reserved bits set");
    a_port_code: assert property (dd && hrdata_o[15]
        |-> hrdata_o[9:8] inside {2'h1, 2'h2})
        else $error("bad port code");
    a_bcast_mcast: assert property (dd && hrdata_o[7] |-> hrdata_o[6])
        else $error("broadcast without multicast");
    a_ucast_excl: assert property (dd && hrdata_o[15]
        |-> hrdata_o[5] != hrdata_o[6])
        else $error("unicast flag wrong");
    a_runt_type: assert property (dd && hrdata_o[1] |-> !hrdata_o[3])
        else $error("type bit on runt");
    a_long_count: assert property (dd && hrdata_o[2]
        |-> hrdata_o[26:16] > 11'd1514)
        else $error("too long flag on short count");
endmodule

bind rxqfd_frame_descriptor rxqfd_chk u_chk (.core_clk_i, .sys_rst_i,
    .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
    .hreadyout_o);

/* File: verification/rxqfd_mac_model.sv */
`timescale 1ns/1ps
module rxqfd_mac_model (
    // clock
    input  wire logic             core_clk_i,
    // frame stream toward the block
    output rxqfd_pkg::rxqfd_mac_t mac_o
);
    rxqfd_pkg::rxqfd_mac_t fr_r = '0;
    logic [7:0]            idle_r = 8'h00;
    logic [7:0]            sent [0:2047];

    // idle lane keeps moving so a stale byte is never mistaken for data
    always @(posedge core_clk_i) idle_r <= idle_r + 8'h35;
    always_comb begin
        mac_o = fr_r;
        if (!fr_r.valid) mac_o.data = idle_r;
    end

    // da: 0 unicast, 1 multicast, 2 broadcast
    task automatic send(input logic [10:0] n, input logic p2, co, ce,
                        input logic [1:0] da, input logic [15:0] lt);
        logic [7:0] b;
        for (int k = 0; k < n; k++) begin
            b = 8'($urandom);
            if (k < 6 && da == 2'h2) b = 8'hff;
            if (k == 0 && da != 2'h2) b[0] = da[0];
            if (k == 12) b = lt[15:8];
            if (k == 13) b = lt[7:0];
            sent[k] = b;
            @(posedge core_clk_i);
            fr_r <= '{valid: 1'b1, sop: k == 0, eop: k == n - 1, data: b,
                      port2: p2, collision: co && k == n - 1,
                      crc_err: ce && k == n - 1};
        end
        @(posedge core_clk_i);
        fr_r <= '0;
    endtask
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
    logic                  core_clk_i = 1'b0;
    logic                  sys_rst_i = 1'b1;
    rxqfd_pkg::rxqfd_mac_t mac;
    logic                  hsel = 1'b0;
    logic                  hwrite = 1'b0;
    logic                  rd_wait = 1'b0;
    logic [1:0]            htrans = 2'h0;
    logic [31:0]           haddr = 32'h0;
    logic [31:0]           hwdata = 32'h0;
    logic [31:0]           hrdata;
    logic                  hrdy;
    logic                  irq;
    logic [95:0]           e_v;
    logic [95:0]           q [$];
    int                    err_total = 0;
    int                    tests_run = 0;
    int                    cyc = 0;

    always #4 core_clk_i = ~core_clk_i;

    rxqfd_mac_model u_mac (.core_clk_i(core_clk_i), .mac_o(mac));
    rxqfd_frame_descriptor u_dut (.core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i), .mac_i(mac), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .irq_o(irq));

    task chk(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask

    task stop_test;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test;
        end
    end

    // read data is judged at the edge that ends the data phase
    always @(posedge core_clk_i) begin
        if (rd_wait && hrdy) begin
            e_v = q.pop_front();
            chk($sformatf("rd %h", e_v[95:64]), hrdata & e_v[31:0],
                e_v[63:32]);
        end
    end

    task bus(input logic w, input logic [31:0] a, d);
        @(posedge core_clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge core_clk_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_wait <= !w;
        do @(posedge core_clk_i); while (hrdy !== 1'b1);
        rd_wait <= 1'b0;
    endtask

    task rd(input logic [31:0] a, v, m);
        q.push_back({a, v, m});
        bus(1'b0, a, 32'h0);
    endtask

    function automatic logic [31:0] desc(input logic [10:0] n,
        input logic p2, co, ce, st, input logic [1:0] da,
        input logic [15:0] lt);
        logic       rn;
        logic [10:0] c;
        rn = co || n < 11'd64;
        c = st ? n - 11'd4 : n;
        return {5'h00, c, 1'b1, 5'h00, p2, !p2, da == 2'h2, da != 2'h0,
                da == 2'h0, 1'b0, !rn && lt > 16'h05dc, n > 11'd1518, rn,
                ce};
    endfunction

    task run(input logic [10:0] n, input logic p2, co, ce, st, pb,
             input logic [1:0] da, input logic [15:0] lt);
        logic      ok;
        logic [10:0] j;
        ok = pb || !(co || ce || n < 11'd64 || n > 11'd1518);
        j = n > 11'd1916 ? 11'd1912 : (n - 11'd4) & 11'h7fc;
        bus(1'b1, 32'h0, {30'h0, st, pb});
        fork
            u_mac.send(n, p2, co, ce, da, lt);
            begin
                repeat (8) @(posedge core_clk_i);
                rd(32'h4, 32'h2, 32'h3);
            end
        join
        repeat (3) @(posedge core_clk_i);
        rd(32'h8, {30'h0, !ok, ok}, 32'h3);
        chk("irq", irq, ok);
        if (ok) begin
            rd(32'h1000, desc(n, p2, co, ce, st, da, lt), '1);
            rd(32'h1004, {u_mac.sent[3], u_mac.sent[2], u_mac.sent[1],
                u_mac.sent[0]}, '1);
            rd(32'h1004 + j, {u_mac.sent[j + 3], u_mac.sent[j + 2],
                u_mac.sent[j + 1], u_mac.sent[j]}, '1);
        end
        bus(1'b1, 32'h8, 32'h7);
        bus(1'b1, 32'h0, {29'h0, 1'b1, st, pb});
    endtask

    initial begin
        void'($urandom(32'h3959));
        repeat (6) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rd(32'h0, 32'h0, 32'h7);
        bus(1'b1, 32'hc, 32'h1);
        rd(32'hc, 32'h1, 32'h7);
        bus(1'b1, 32'h10, $urandom);
        rd(32'h10, 32'h0, '1);
        run(11'd64, 0, 0, 0, 0, 0, 2'h0, 16'h0800);
        run(11'd100, 1, 0, 0, 1, 0, 2'h1, 16'h0040);
        run(11'd70, 0, 0, 0, 0, 0, 2'h2, 16'h05dc);
        run(11'd1518, 1, 0, 0, 0, 0, 2'h0, 16'h05dd);
        run(11'd1519, 1, 0, 0, 1, 1, 2'h1, 16'h05dd);
        run(11'd1519, 0, 0, 0, 0, 0, 2'h0, 16'h0800);
        run(11'd64, 0, 0, 1, 0, 0, 2'h0, 16'h0800);
        run(11'd64, 1, 0, 1, 0, 1, 2'h2, 16'h0800);
        run(11'd63, 1, 0, 0, 0, 1, 2'h0, 16'h0800);
        run(11'd64, 0, 1, 0, 0, 0, 2'h0, 16'h0800);
        run(11'd80, 0, 1, 0, 1, 1, 2'h1, 16'h0900);
        run(11'd1930, 1, 0, 0, 0, 1, 2'h0, 16'h0800);
        run(11'd64 + 11'($urandom % 1400), $urandom, 0, 0, $urandom, 0,
            2'($urandom % 3), 16'($urandom));
        // a second frame arriving while one is held must not disturb it
        bus(1'b1, 32'h0, 32'h0);
        u_mac.send(11'd64, 1, 0, 0, 2'h1, 16'h0800);
        repeat (3) @(posedge core_clk_i);
        u_mac.send(11'd90, 0, 0, 0, 2'h0, 16'h0100);
        repeat (3) @(posedge core_clk_i);
        rd(32'h8, 32'h5, 32'h7);
        rd(32'h1000, desc(11'd64, 1, 0, 0, 0, 2'h1, 16'h0800), '1);
        bus(1'b1, 32'hc, 32'h0);
        repeat (2) @(posedge core_clk_i);
        chk("irq", irq, 1'b0);
        bus(1'b1, 32'hc, 32'h4);
        repeat (2) @(posedge core_clk_i);
        chk("irq", irq, 1'b1);
        bus(1'b1, 32'h8, 32'h7);
        repeat (2) @(posedge core_clk_i);
        chk("irq", irq, 1'b0);
        stop_test;
    end
endmodule
